/* File: tbfr_pkg.sv */
// Package with register map, field positions and timing constants
package tbfr_pkg;
   localparam logic [7:0] ADDR_TYPEB_CFG  = 8'h1e;
   localparam logic [7:0] ADDR_UART_SPEED = 8'h1f;
   localparam logic [7:0] ADDR_RSVD_A     = 8'h20;
   localparam logic [7:0] ADDR_CRC_HIGH   = 8'h21;
   localparam logic [7:0] ADDR_CRC_LOW    = 8'h22;
   localparam logic [7:0] ADDR_RSVD_B     = 8'h23;

   localparam logic [7:0] RST_TYPEB_CFG   = 8'h00;
   localparam logic [7:0] RST_UART_SPEED  = 8'heb;
   localparam logic [7:0] RST_RSVD_A      = 8'h00;
   localparam logic [7:0] RST_CRC         = 8'hff;
   localparam logic [7:0] RST_RSVD_B      = 8'h88;
   localparam logic [7:0] TYPEB_WR_MASK   = 8'hdf;

   localparam int BIT_RX_SOF_REQ   = 7;
   localparam int BIT_RX_EOF_REQ   = 6;
   localparam int BIT_MARKER_WIDTH = 4;
   localparam int BIT_TX_SOF_SUPP  = 3;
   localparam int BIT_TX_EOF_SUPP  = 2;

   // Marker lengths in ETU, adjust and ETU length in clock cycles
   localparam int SOF_LOW_MIN_ETU  = 10;
   localparam int SOF_LOW_MAX_ETU  = 11;
   localparam int SOF_HIGH_MIN_ETU = 2;
   localparam int SOF_HIGH_MAX_ETU = 3;
   localparam int EOF_LOW_MIN_ETU  = 10;
   localparam int EOF_LOW_MAX_ETU  = 11;
   localparam int ADJ_LOW_ETU      = 11;
   localparam int ADJ_HIGH_ETU     = 2;
   localparam int ADJ_CYCLES       = 8;
   localparam int ETU_CYCLES       = 128;

   typedef enum logic [2:0] {
      TX_IDLE     = 3'b000,
      TX_SOF_LOW  = 3'b001,
      TX_SOF_HIGH = 3'b010,
      TX_DATA     = 3'b011,
      TX_EOF_LOW  = 3'b100,
      TX_GUARD    = 3'b101
   } tbfr_tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE    = 2'b00,
      RX_DATA    = 2'b01,
      RX_DISCARD = 2'b10
   } tbfr_rx_state_t;
endpackage

/* File: tbfr_tx_framer.sv */
// Type B transmit framer: start marker, data bits, end marker, guard bits
module tbfr_tx_framer (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Configuration
   input  wire logic       marker_width_select,
   input  wire logic       marker_length_adjust,
   input  wire logic       tx_start_marker_suppress,
   input  wire logic       tx_end_marker_suppress,
   input  wire logic [1:0] extra_guard_bits,
   // Frame control
   input  wire logic       tx_start,
   input  wire logic       tx_last_bit,
   input  wire logic       tx_bit,
   output logic            tx_bit_take,
   output logic            tx_busy,
   output logic            tx_out
);
   typedef struct packed {
      tbfr_pkg::tbfr_tx_state_t st;
      logic [11:0]              cnt;
      logic [1:0]               guard;
      logic                     last;
      logic                     out;
   } tbfr_tx_t;

   tbfr_tx_t s_r, s_nxt;

   function automatic logic [11:0] etu(input int n, input int adj);
      etu = 12'(n * tbfr_pkg::ETU_CYCLES + adj);
   endfunction

   logic [11:0] sof_low, sof_high, eof_low;

   always_comb begin
      if (marker_width_select && marker_length_adjust) begin
         sof_low  = etu(tbfr_pkg::ADJ_LOW_ETU, -tbfr_pkg::ADJ_CYCLES);
         sof_high = etu(tbfr_pkg::ADJ_HIGH_ETU, tbfr_pkg::ADJ_CYCLES);
         eof_low  = etu(tbfr_pkg::ADJ_LOW_ETU, -tbfr_pkg::ADJ_CYCLES);
      end else if (marker_width_select) begin
         sof_low  = etu(tbfr_pkg::SOF_LOW_MAX_ETU, 0);
         sof_high = etu(tbfr_pkg::SOF_HIGH_MAX_ETU, 0);
         eof_low  = etu(tbfr_pkg::EOF_LOW_MAX_ETU, 0);
      end else begin
         sof_low  = etu(tbfr_pkg::SOF_LOW_MIN_ETU, 0);
         sof_high = etu(tbfr_pkg::SOF_HIGH_MIN_ETU, 0);
         eof_low  = etu(tbfr_pkg::EOF_LOW_MIN_ETU, 0);
      end
   end

   logic [11:0] bit_len;
   assign bit_len = etu(1, 0);

   always_comb begin
      s_nxt = s_r;
      tx_bit_take = 1'b0;
      if (s_r.cnt != 12'h000)
         s_nxt.cnt = s_r.cnt - 12'h001;
      case (s_r.st)
         tbfr_pkg::TX_IDLE: begin
            s_nxt.out = 1'b1;
            if (tx_start) begin
               s_nxt.guard = extra_guard_bits;
               if (tx_start_marker_suppress) begin
                  s_nxt.st  = tbfr_pkg::TX_DATA;
                  s_nxt.cnt = 12'h000;
               end else begin
                  s_nxt.st  = tbfr_pkg::TX_SOF_LOW;
                  s_nxt.cnt = sof_low - 12'h001;
                  s_nxt.out = 1'b0;
               end
            end
         end
         tbfr_pkg::TX_SOF_LOW:
            if (s_r.cnt == 12'h000) begin
               s_nxt.st  = tbfr_pkg::TX_SOF_HIGH;
               // Data state holds the line high one cycle before its first bit
               s_nxt.cnt = sof_high - 12'h002;
               s_nxt.out = 1'b1;
            end
         tbfr_pkg::TX_SOF_HIGH:
            if (s_r.cnt == 12'h000) begin
               s_nxt.st  = tbfr_pkg::TX_DATA;
            end
         tbfr_pkg::TX_DATA:
            if (s_r.cnt == 12'h000) begin
               if (s_r.last) begin
                  s_nxt.last = 1'b0;
                  if (tx_end_marker_suppress) begin
                     s_nxt.st  = tbfr_pkg::TX_GUARD;
                     s_nxt.out = 1'b1;
                     s_nxt.cnt = etu(int'(s_r.guard), 0);
                  end else begin
                     s_nxt.st  = tbfr_pkg::TX_EOF_LOW;
                     s_nxt.out = 1'b0;
                     s_nxt.cnt = eof_low - 12'h001;
                  end
               end else begin
                  tx_bit_take = 1'b1;
                  s_nxt.out  = tx_bit;
                  s_nxt.last = tx_last_bit;
                  s_nxt.cnt  = bit_len - 12'h001;
               end
            end
         tbfr_pkg::TX_EOF_LOW:
            if (s_r.cnt == 12'h000) begin
               s_nxt.st  = tbfr_pkg::TX_GUARD;
               s_nxt.out = 1'b1;
               s_nxt.cnt = etu(int'(s_r.guard), 0);
            end
         tbfr_pkg::TX_GUARD:
            if (s_r.cnt == 12'h000)
               s_nxt.st = tbfr_pkg::TX_IDLE;
         default: s_nxt.st = tbfr_pkg::TX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset)
         s_r <= '{st: tbfr_pkg::TX_IDLE, cnt: 12'h000, guard: 2'h0, last: 1'b0, out: 1'b1};
      else
         s_r <= s_nxt;
   end

   assign tx_busy = (s_r.st != tbfr_pkg::TX_IDLE);
   assign tx_out  = s_r.out;
endmodule

/* File: tbfr_rx_filter.sv */
// Type B receive marker filter: strips markers, drops or flags streams
module tbfr_rx_filter (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Configuration
   input  wire logic       rx_start_marker_required,
   input  wire logic       rx_end_marker_required,
   // Decoded stream from the demodulator
   input  wire logic       rx_frame_start,
   input  wire logic       rx_sof_seen,
   input  wire logic       rx_byte_valid,
   input  wire logic [7:0] rx_byte,
   input  wire logic       rx_frame_end,
   input  wire logic       rx_eof_seen,
   // Output to the FIFO
   output logic            fifo_wr,
   output logic [7:0]      fifo_data,
   output logic            protocol_error
);
   typedef struct packed {
      tbfr_pkg::tbfr_rx_state_t st;
      logic                     wr;
      logic [7:0]               data;
      logic                     perr;
   } tbfr_rx_t;

   tbfr_rx_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.wr = 1'b0;
      s_nxt.perr = 1'b0;
      case (s_r.st)
         tbfr_pkg::RX_IDLE:
            if (rx_frame_start) begin
               if (rx_start_marker_required && !rx_sof_seen)
                  s_nxt.st = tbfr_pkg::RX_DISCARD;
               else
                  s_nxt.st = tbfr_pkg::RX_DATA;
            end
         tbfr_pkg::RX_DATA: begin
            // Only data bytes reach the FIFO, markers never do
            if (rx_byte_valid) begin
               s_nxt.wr   = 1'b1;
               s_nxt.data = rx_byte;
            end
            if (rx_frame_end) begin
               s_nxt.st   = tbfr_pkg::RX_IDLE;
               s_nxt.perr = rx_end_marker_required && !rx_eof_seen;
            end
         end
         tbfr_pkg::RX_DISCARD:
            if (rx_frame_end)
               s_nxt.st = tbfr_pkg::RX_IDLE;
         default: s_nxt.st = tbfr_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset)
         s_r <= '{st: tbfr_pkg::RX_IDLE, wr: 1'b0, data: 8'h00, perr: 1'b0};
      else
         s_r <= s_nxt;
   end

   assign fifo_wr        = s_r.wr;
   assign fifo_data      = s_r.data;
   assign protocol_error = s_r.perr;
endmodule

/* File: tbfr_regs.sv */
// Type B framing, UART speed and checksum result register bank
//
// Summary of operation
// - Start marker required: drop streams lacking it
// - Start marker optional: accept, strip marker
// - End marker required: missing marker flags error
// - End marker optional: accept, strip marker
// - Width one, adjust zero: maximum markers
// - Both one: 11 ETU-8, 2 ETU+8 markers
// - Width zero, adjust zero: minimum markers
// - Guard field adds zero to three bits
// - Coarse speed bits 7:5, reset EBh
// - Fine speed bits 4:0 set rate too
// - Checksum bytes read-only at 21h/22h, FFh
// - Framing register 1Eh resets 00h, bit5 reserved
// - Slots 20h and 23h inert, 00h/88h
module tbfr_regs (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // Checksum engine
   input  wire logic [15:0] checksum_value,
   input  wire logic        checksum_load,
   input  wire logic        checksum_ready_flag,
   // Marker adjust from the self-test register
   input  wire logic       marker_length_adjust,
   // UART speed factors
   output logic [2:0]      uart_coarse_speed_factor,
   output logic [4:0]      uart_fine_speed_factor,
   // Transmit side
   input  wire logic       tx_start,
   input  wire logic       tx_last_bit,
   input  wire logic       tx_bit,
   output logic            tx_bit_take,
   output logic            tx_busy,
   output logic            tx_out,
   // Receive side
   input  wire logic       rx_frame_start,
   input  wire logic       rx_sof_seen,
   input  wire logic       rx_byte_valid,
   input  wire logic [7:0] rx_byte,
   input  wire logic       rx_frame_end,
   input  wire logic       rx_eof_seen,
   output logic            fifo_wr,
   output logic [7:0]      fifo_data,
   output logic            protocol_error
);
   typedef struct packed {
      logic [7:0] typeb;
      logic [7:0] speed;
      logic [7:0] crc_hi;
      logic [7:0] crc_lo;
      logic [7:0] rdata;
   } tbfr_regs_t;

   tbfr_regs_t s_r, s_nxt;

   function automatic logic [7:0] read_mux(input tbfr_regs_t s, input logic [7:0] a);
      case (a)
         tbfr_pkg::ADDR_TYPEB_CFG:  read_mux = s.typeb;
         tbfr_pkg::ADDR_UART_SPEED: read_mux = s.speed;
         tbfr_pkg::ADDR_RSVD_A:     read_mux = tbfr_pkg::RST_RSVD_A;
         tbfr_pkg::ADDR_CRC_HIGH:   read_mux = s.crc_hi;
         tbfr_pkg::ADDR_CRC_LOW:    read_mux = s.crc_lo;
         tbfr_pkg::ADDR_RSVD_B:     read_mux = tbfr_pkg::RST_RSVD_B;
         default:                   read_mux = 8'h00;
      endcase
   endfunction

   always_comb begin
      s_nxt = s_r;
      if (reg_wr && reg_addr == tbfr_pkg::ADDR_TYPEB_CFG)
         s_nxt.typeb = reg_wdata & tbfr_pkg::TYPEB_WR_MASK;
      if (reg_wr && reg_addr == tbfr_pkg::ADDR_UART_SPEED)
         s_nxt.speed = reg_wdata;
      // Checksum bytes only change from the engine
      if (checksum_load) begin
         s_nxt.crc_hi = checksum_value[15:8];
         s_nxt.crc_lo = checksum_value[7:0];
      end
      s_nxt.rdata = reg_rd ? read_mux(s_r, reg_addr) : 8'h00;
   end

   always_ff @(posedge clk_sys) begin
      if (reset)
         s_r <= '{typeb:  tbfr_pkg::RST_TYPEB_CFG,
                  speed:  tbfr_pkg::RST_UART_SPEED,
                  crc_hi: tbfr_pkg::RST_CRC,
                  crc_lo: tbfr_pkg::RST_CRC,
                  rdata:  8'h00};
      else
         s_r <= s_nxt;
   end

   assign reg_rdata                = s_r.rdata;
   assign uart_coarse_speed_factor = s_r.speed[7:5];
   assign uart_fine_speed_factor   = s_r.speed[4:0];

   tbfr_tx_framer u_tx (
      .clk_sys                  (clk_sys),
      .reset                    (reset),
      .marker_width_select      (s_r.typeb[tbfr_pkg::BIT_MARKER_WIDTH]),
      .marker_length_adjust     (marker_length_adjust),
      .tx_start_marker_suppress (s_r.typeb[tbfr_pkg::BIT_TX_SOF_SUPP]),
      .tx_end_marker_suppress   (s_r.typeb[tbfr_pkg::BIT_TX_EOF_SUPP]),
      .extra_guard_bits         (s_r.typeb[1:0]),
      .tx_start                 (tx_start),
      .tx_last_bit              (tx_last_bit),
      .tx_bit                   (tx_bit),
      .tx_bit_take              (tx_bit_take),
      .tx_busy                  (tx_busy),
      .tx_out                   (tx_out)
   );

   tbfr_rx_filter u_rx (
      .clk_sys                  (clk_sys),
      .reset                    (reset),
      .rx_start_marker_required (s_r.typeb[tbfr_pkg::BIT_RX_SOF_REQ]),
      .rx_end_marker_required   (s_r.typeb[tbfr_pkg::BIT_RX_EOF_REQ]),
      .rx_frame_start           (rx_frame_start),
      .rx_sof_seen              (rx_sof_seen),
      .rx_byte_valid            (rx_byte_valid),
      .rx_byte                  (rx_byte),
      .rx_frame_end             (rx_frame_end),
      .rx_eof_seen              (rx_eof_seen),
      .fifo_wr                  (fifo_wr),
      .fifo_data                (fifo_data),
      .protocol_error           (protocol_error)
   );
endmodule

/* File: tbfr_regs_props.sv */
// Checker on the top ports of the framing register bank
module tbfr_regs_props (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        reset,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [15:0] checksum_value,
   input wire logic        checksum_load,
   input wire logic [2:0]  uart_coarse_speed_factor,
   input wire logic [4:0]  uart_fine_speed_factor,
   // Framing
   input wire logic        tx_start,
   input wire logic        tx_busy,
   input wire logic        tx_out,
   input wire logic        rx_byte_valid,
   input wire logic [7:0]  rx_byte,
   input wire logic        rx_frame_end,
   input wire logic        rx_eof_seen,
   input wire logic        fifo_wr,
   input wire logic [7:0]  fifo_data,
   input wire logic        protocol_error
);
   logic [15:0] ck_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // Last loaded checksum, as software should see it
   always_ff @(posedge clk_sys) begin
      if (reset)
         ck_r <= 16'hffff;
      else if (checksum_load)
         ck_r <= checksum_value;
   end

   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_speed_read_back: assert property (reg_rd && reg_addr == 8'h1f |=>
      reg_rdata == {uart_coarse_speed_factor, uart_fine_speed_factor})
      else $error("speed read differs from factor ports");
   a_crc_high_read: assert property (reg_rd && reg_addr == 8'h21 && !checksum_load |=>
      reg_rdata == ck_r[15:8])
      else $error("checksum high byte wrong");
   a_framing_bit_five: assert property (reg_rd && reg_addr == 8'h1e |=> !reg_rdata[5])
      else $error("reserved framing bit reads one");
   a_slot_b_const: assert property (reg_rd && reg_addr == 8'h23 |=> reg_rdata == 8'h88)
      else $error("slot b not constant");
   a_tx_launch_busy: assert property (tx_start && !tx_busy |=> tx_busy)
      else $error("transmit did not start");
   a_tx_idle_high: assert property (!tx_busy && !$past(tx_busy) |-> tx_out)
      else $error("line not high while idle");
   a_fifo_from_byte: assert property (fifo_wr |-> $past(rx_byte_valid) && fifo_data == $past(rx_byte))
      else $error("fifo write without byte");
   a_perr_cause: assert property (protocol_error |-> $past(rx_frame_end) && !$past(rx_eof_seen))
      else $error("protocol error without missing end marker");
endmodule

/* File: tbfr_tx_source.sv */
// Transmit data source: a zero bit, then a one bit marked last
module tbfr_tx_source (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Framer handshake
   input wire logic tx_start,
   input wire logic tx_bit_take,
   output logic     tx_bit,
   output logic     tx_last_bit
);
   logic idx_r;

   always_ff @(posedge clk_sys) begin
      if (reset || tx_start)
         idx_r <= 1'b0;
      else if (tx_bit_take)
         idx_r <= 1'b1;
   end

   assign tx_bit      = idx_r;
   assign tx_last_bit = idx_r;
endmodule

/* File: typeb_framing_uart_speed_crc_regs_tb_top.sv */
// Testbench for the framing, speed and checksum register bank
module typeb_framing_uart_speed_crc_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int E = tbfr_pkg::ETU_CYCLES;
   // cfg, adjust, low runs, first low, last low, start high
   localparam int TX_TAB[6][6] = '{
      '{8'h11, 0, 3, 11*E,   11*E,   3*E},
      '{8'h12, 1, 3, 11*E-8, 11*E-8, 2*E+8},
      '{8'h03, 0, 3, 10*E,   10*E,   2*E},
      '{8'h00, 0, 3, 10*E,   10*E,   2*E},
      '{8'h08, 0, 2, E,      10*E,   0},
      '{8'h04, 0, 2, 10*E,   E,      2*E}};
   logic [7:0]  rst_exp [7] = '{8'h00, 8'heb, 8'h00, 8'hff, 8'hff, 8'h88, 8'h00};
   logic        clk_sys, reset, reg_wr, reg_rd, checksum_load, checksum_ready_flag, marker_length_adjust;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rx_byte, fifo_data, last_fifo;
   logic [15:0] checksum_value;
   logic [2:0]  uart_coarse_speed_factor;
   logic [4:0]  uart_fine_speed_factor;
   logic        tx_start, tx_last_bit, tx_bit, tx_bit_take, tx_busy, tx_out;
   logic        rx_frame_start, rx_sof_seen, rx_byte_valid, rx_frame_end, rx_eof_seen, fifo_wr, protocol_error;
   int          bad_count, cmp_count, wr_cnt, err_cnt;
   int          lows[$], highs[$];

   tbfr_regs dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .checksum_value(checksum_value),
      .checksum_load(checksum_load), .checksum_ready_flag(checksum_ready_flag),
      .marker_length_adjust(marker_length_adjust), .uart_coarse_speed_factor(uart_coarse_speed_factor),
      .uart_fine_speed_factor(uart_fine_speed_factor), .tx_start(tx_start), .tx_last_bit(tx_last_bit),
      .tx_bit(tx_bit), .tx_bit_take(tx_bit_take), .tx_busy(tx_busy), .tx_out(tx_out),
      .rx_frame_start(rx_frame_start), .rx_sof_seen(rx_sof_seen), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .rx_eof_seen(rx_eof_seen), .fifo_wr(fifo_wr),
      .fifo_data(fifo_data), .protocol_error(protocol_error));
   tbfr_tx_source src (.clk_sys(clk_sys), .reset(reset), .tx_start(tx_start), .tx_bit_take(tx_bit_take),
      .tx_bit(tx_bit), .tx_last_bit(tx_last_bit));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (!reset && fifo_wr === 1'b1) begin
         wr_cnt++;
         last_fifo = fifo_data;
      end
      if (!reset && protocol_error === 1'b1)
         err_cnt++;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] x);
      cmp_count++;
      if (got !== x) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, x);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk(16'(reg_rdata), 16'(x));
   endtask

   task automatic rx_frame(input logic sof, input logic eof, input logic [7:0] b);
      @(posedge clk_sys);
      rx_frame_start <= 1'b1;
      rx_sof_seen    <= sof;
      @(posedge clk_sys);
      rx_frame_start <= 1'b0;
      rx_byte_valid  <= 1'b1;
      rx_byte        <= b;
      @(posedge clk_sys);
      rx_byte_valid <= 1'b0;
      rx_frame_end  <= 1'b1;
      rx_eof_seen   <= eof;
      @(posedge clk_sys);
      rx_frame_end <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   // Sends one frame and measures low and high runs of the line
   task automatic tx_frame(input int r);
      int   n;
      int   g;
      logic prev;
      wr(8'h1e, 8'(TX_TAB[r][0]));
      marker_length_adjust <= (TX_TAB[r][1] != 0);
      lows.delete();
      highs.delete();
      @(posedge clk_sys);
      tx_start <= 1'b1;
      @(posedge clk_sys);
      tx_start <= 1'b0;
      prev = 1'b1;
      n = 0;
      repeat (8000) begin
         @(negedge clk_sys);
         if (tx_busy !== 1'b1)
            break;
         if (tx_out !== prev) begin
            if (prev && n > 0)
               highs.push_back(n);
            else if (!prev)
               lows.push_back(n);
            n = 0;
            prev = tx_out;
         end
         n++;
      end
      g = prev ? n : 0;
      if (!prev)
         lows.push_back(n);
      g = g - ((TX_TAB[r][0] & 3) + ((TX_TAB[r][0] >> 2) & 1)) * E;
      chk(16'(lows.size()), 16'(TX_TAB[r][2]));
      chk(16'(lows[0]), 16'(TX_TAB[r][3]));
      chk(16'(lows[$]), 16'(TX_TAB[r][4]));
      if (TX_TAB[r][5] > 0)
         chk(16'(highs[0]), 16'(TX_TAB[r][5]));
      chk(16'(g >= 0 && g <= 1), 16'h1);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      {reg_wr, reg_rd, checksum_load, checksum_ready_flag, marker_length_adjust, tx_start} = '0;
      {reg_addr, reg_wdata, rx_byte, checksum_value} = '0;
      {rx_frame_start, rx_sof_seen, rx_byte_valid, rx_frame_end, rx_eof_seen} = '0;
      reset = 1'b1;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      for (int i = 0; i < 7; i++) rdchk(i < 6 ? 8'h1e + 8'(i) : 8'h30, rst_exp[i]);
      chk(16'({uart_coarse_speed_factor, uart_fine_speed_factor}), 16'h00eb);
      $display("test reset values done");
      wr(8'h1e, 8'hff);
      wr(8'h1f, 8'h5a);
      for (int i = 2; i < 7; i++) wr(i < 6 ? 8'h1e + 8'(i) : 8'h30, 8'h55);
      rdchk(8'h1e, 8'hdf);
      rdchk(8'h1f, 8'h5a);
      chk(16'({uart_coarse_speed_factor, uart_fine_speed_factor}), 16'h005a);
      for (int i = 2; i < 7; i++) rdchk(i < 6 ? 8'h1e + 8'(i) : 8'h30, rst_exp[i]);
      $display("test register access done");
      @(posedge clk_sys);
      checksum_value      <= 16'h1234;
      checksum_load       <= 1'b1;
      checksum_ready_flag <= 1'b1;
      @(posedge clk_sys);
      checksum_load <= 1'b0;
      rdchk(8'h21, 8'h12);
      rdchk(8'h22, 8'h34);
      $display("test checksum done");
      wr(8'h1e, 8'hc0);
      rx_frame(1'b0, 1'b1, 8'h3c);
      chk(16'(wr_cnt), 16'h0);
      rx_frame(1'b1, 1'b0, 8'ha5);
      chk(16'(wr_cnt), 16'h1);
      chk(16'(last_fifo), 16'h00a5);
      chk(16'(err_cnt), 16'h1);
      wr(8'h1e, 8'h00);
      rx_frame(1'b0, 1'b0, 8'h96);
      chk(16'(wr_cnt), 16'h2);
      chk(16'(last_fifo), 16'h0096);
      chk(16'(err_cnt), 16'h1);
      $display("test receive done");
      // Width zero is only ever paired with adjust zero
      for (int r = 0; r < 6; r++) tx_frame(r);
      $display("test transmit done");
      print_verdict();
   end

   initial begin
      #(60000 * 20);
      bad_count++;
      print_verdict();
   end
endmodule

bind tbfr_regs tbfr_regs_props u_props (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .checksum_value(checksum_value), .checksum_load(checksum_load),
   .uart_coarse_speed_factor(uart_coarse_speed_factor), .uart_fine_speed_factor(uart_fine_speed_factor),
   .tx_start(tx_start), .tx_busy(tx_busy), .tx_out(tx_out), .rx_byte_valid(rx_byte_valid),
   .rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .rx_eof_seen(rx_eof_seen), .fifo_wr(fifo_wr),
   .fifo_data(fifo_data), .protocol_error(protocol_error));
